// ==== rtl/cti_core.v ====
// 8-bit accumulator cpu core: trap, wait, test, transfers, moves and address modes
// What this block does
// - trap sets mask, loads pc from vector
// - wait clears mask, halts until interrupt
// - test sets n z, clears v only
// - word indexed: two offset bytes plus index
// - byte indexed: unsigned byte plus index
// - prefixed byte offset added to stack pointer
// - prefixed word offset added to stack pointer
// - extended: two address bytes, high first
// - index post-increment after no-offset access
// - byte offset index, then index increments
// - move copies direct source to direct destination
// - move direct to index address, then increment
// - move from index address, increment, to direct
// - move immediate byte to direct destination
// - branch-on-memory: address byte, then offset byte
// - relative offset is signed, added to pc
`timescale 1ns/1ps
`include "cti_map.vh"

module cti_core (
    sys_clk,
    rst_n,
    mem_rdata,
    irq_req,
    mem_addr,
    mem_wdata,
    mem_we,
    mem_re,
    core_waiting,
    acc_val,
    index_val,
    stack_pointer,
    program_counter,
    condition_code_register
);
    input  wire        sys_clk;
    input  wire        rst_n;
    input  wire [7:0]  mem_rdata;
    input  wire        irq_req;
    output reg  [15:0] mem_addr;
    output reg  [7:0]  mem_wdata;
    output reg         mem_we;
    output reg         mem_re;
    output wire        core_waiting;
    output wire [7:0]  acc_val;
    output wire [15:0] index_val;
    output wire [15:0] stack_pointer;
    output wire [15:0] program_counter;
    output wire [7:0]  condition_code_register;

    localparam ST_FETCH = 9'h001;
    localparam ST_OPND  = 9'h002;
    localparam ST_READ  = 9'h004;
    localparam ST_DST   = 9'h008;
    localparam ST_WRITE = 9'h010;
    localparam ST_REL   = 9'h020;
    localparam ST_XFER  = 9'h040;
    localparam ST_SWI   = 9'h080;
    localparam ST_WAIT  = 9'h100;

    localparam C_NOP  = 5'd0;
    localparam C_SWI  = 5'd1;
    localparam C_WAIT = 5'd2;
    localparam C_TAP  = 5'd3;
    localparam C_TPA  = 5'd4;
    localparam C_TSX  = 5'd5;
    localparam C_TXS  = 5'd6;
    localparam C_TAX  = 5'd7;
    localparam C_TXA  = 5'd8;
    localparam C_TSTA = 5'd9;
    localparam C_TSTX = 5'd10;
    localparam C_TST  = 5'd11;
    localparam C_LDA  = 5'd12;
    localparam C_CBEQ = 5'd13;
    localparam C_MDD  = 5'd14;
    localparam C_MDIX = 5'd15;
    localparam C_MIXD = 5'd16;
    localparam C_MIMD = 5'd17;
    localparam C_BRA  = 5'd18;

    reg [8:0]  st_q;
    reg [15:0] pc_q;
    reg [15:0] sp_q;
    reg [7:0]  a_q;
    reg [7:0]  h_q;
    reg [7:0]  x_q;
    reg [7:0]  ccr_q;
    reg [7:0]  dat_q;
    reg [7:0]  off_hi_q;
    reg [7:0]  off_lo_q;
    reg [15:0] wa_q;
    reg [4:0]  cls_q;
    reg [3:0]  mode_q;
    reg [1:0]  cnt_q;
    reg [2:0]  step_q;
    reg        pfx_q;

    reg [4:0]  dec_cls;
    reg [3:0]  dec_mode;
    reg [1:0]  dec_nb;
    reg [7:0]  flg_val;
    reg        flg_nz;
    reg        flg_all;

    wire [15:0] hx = {h_q, x_q};
    wire [15:0] hx_inc = hx + 16'h0001;
    wire [15:0] pc_inc = pc_q + 16'h0001;
    wire [15:0] ea;
    wire [7:0]  flg_ccr;
    wire        postinc = (mode_q == `CTI_M_IXP) || (mode_q == `CTI_M_IX1P);
    wire        take = (cls_q == C_BRA) || ((cls_q == C_CBEQ) && (a_q == dat_q));
    wire [15:0] rel_ext = take ? {{8{mem_rdata[7]}}, mem_rdata} : 16'h0000;

    assign core_waiting            = st_q[8];
    assign acc_val                 = a_q;
    assign index_val               = hx;
    assign stack_pointer           = sp_q;
    assign program_counter         = pc_q;
    assign condition_code_register = ccr_q;

    cti_agen u_agen (
        .mode   (mode_q),
        .hx     (hx),
        .sp     (sp_q),
        .off_hi (off_hi_q),
        .off_lo (off_lo_q),
        .ea     (ea)
    );

    cti_flags u_flags (
        .ccr_in  (ccr_q),
        .val     (flg_val),
        .ld_nz   (flg_nz),
        .ld_all  (flg_all),
        .ccr_out (flg_ccr)
    );

    // opcode decode; the prefix byte selects the stack-relative page
    always @* begin
        dec_cls  = C_NOP;
        dec_mode = `CTI_M_IX;
        dec_nb   = 2'd0;
        case ({pfx_q, mem_rdata})
            {1'b0, `CTI_OP_SWI}:  dec_cls = C_SWI;
            {1'b0, `CTI_OP_WAIT}: dec_cls = C_WAIT;
            {1'b0, `CTI_OP_TAP}:  dec_cls = C_TAP;
            {1'b0, `CTI_OP_TPA}:  dec_cls = C_TPA;
            {1'b0, `CTI_OP_TSX}:  dec_cls = C_TSX;
            {1'b0, `CTI_OP_TXS}:  dec_cls = C_TXS;
            {1'b0, `CTI_OP_TAX}:  dec_cls = C_TAX;
            {1'b0, `CTI_OP_TXA}:  dec_cls = C_TXA;
            {1'b0, `CTI_OP_TSTA}: dec_cls = C_TSTA;
            {1'b0, `CTI_OP_TSTX}: dec_cls = C_TSTX;
            {1'b0, `CTI_OP_BRA}:  dec_cls = C_BRA;
            {1'b0, `CTI_OP_TST_DIR}: {dec_cls, dec_mode, dec_nb} = {C_TST, `CTI_M_DIR, 2'd1};
            {1'b0, `CTI_OP_TST_IX1}: {dec_cls, dec_mode, dec_nb} = {C_TST, `CTI_M_IX1, 2'd1};
            {1'b0, `CTI_OP_TST_IX}: dec_cls = C_TST;
            {1'b1, `CTI_OP_TST_SP1}: {dec_cls, dec_mode, dec_nb} = {C_TST, `CTI_M_SP1, 2'd1};
            {1'b0, `CTI_OP_LDA_EXT}: {dec_cls, dec_mode, dec_nb} = {C_LDA, `CTI_M_EXT, 2'd2};
            {1'b0, `CTI_OP_LDA_IX2}: {dec_cls, dec_mode, dec_nb} = {C_LDA, `CTI_M_IX2, 2'd2};
            {1'b0, `CTI_OP_LDA_IX1}: {dec_cls, dec_mode, dec_nb} = {C_LDA, `CTI_M_IX1, 2'd1};
            {1'b0, `CTI_OP_LDA_IX}: dec_cls = C_LDA;
            {1'b1, `CTI_OP_LDA_SP2}: {dec_cls, dec_mode, dec_nb} = {C_LDA, `CTI_M_SP2, 2'd2};
            {1'b1, `CTI_OP_LDA_SP1}: {dec_cls, dec_mode, dec_nb} = {C_LDA, `CTI_M_SP1, 2'd1};
            {1'b0, `CTI_OP_CBEQ_DIR}: {dec_cls, dec_mode, dec_nb} = {C_CBEQ, `CTI_M_DIR, 2'd1};
            {1'b0, `CTI_OP_CBEQ_IX1P}: {dec_cls, dec_mode, dec_nb} = {C_CBEQ, `CTI_M_IX1P, 2'd1};
            {1'b0, `CTI_OP_CBEQ_IXP}: {dec_cls, dec_mode, dec_nb} = {C_CBEQ, `CTI_M_IXP, 2'd0};
            {1'b0, `CTI_OP_MOV_DD}: {dec_cls, dec_mode, dec_nb} = {C_MDD, `CTI_M_DIR, 2'd1};
            {1'b0, `CTI_OP_MOV_DIX}: {dec_cls, dec_mode, dec_nb} = {C_MDIX, `CTI_M_DIR, 2'd1};
            {1'b0, `CTI_OP_MOV_IMD}: {dec_cls, dec_mode, dec_nb} = {C_MIMD, `CTI_M_DIR, 2'd1};
            {1'b0, `CTI_OP_MOV_IXD}: dec_cls = C_MIXD;
            default: dec_cls = C_NOP;
        endcase
    end

    always @* begin
        flg_val = mem_rdata;
        flg_nz  = 1'b0;
        flg_all = 1'b0;
        case (st_q)
            ST_FETCH: begin
                flg_val = (dec_cls == C_TSTX) ? x_q : a_q;
                flg_nz  = (dec_cls == C_TSTA) || (dec_cls == C_TSTX);
            end
            ST_READ: flg_nz = (cls_q == C_TST) || (cls_q == C_LDA);
            ST_XFER: begin
                flg_val = a_q;
                flg_all = (cls_q == C_TAP);
            end
            default: flg_nz = 1'b0;
        endcase
    end

    // bus drive; read data is expected in the same cycle as the address
    always @* begin
        mem_addr  = pc_q;
        mem_wdata = dat_q;
        mem_we    = 1'b0;
        mem_re    = 1'b0;
        case (st_q)
            ST_FETCH: mem_re = 1'b1;
            ST_OPND:  mem_re = 1'b1;
            ST_DST:   mem_re = 1'b1;
            ST_REL:   mem_re = 1'b1;
            ST_READ: begin
                mem_addr = ea;
                mem_re   = 1'b1;
            end
            ST_WRITE: begin
                mem_addr = wa_q;
                mem_we   = 1'b1;
            end
            ST_SWI: begin
                mem_addr = sp_q;
                mem_we   = (step_q < 3'h5);
                case (step_q)
                    3'h0: mem_wdata = pc_q[7:0];
                    3'h1: mem_wdata = pc_q[15:8];
                    3'h2: mem_wdata = x_q;
                    3'h3: mem_wdata = a_q;
                    3'h4: mem_wdata = ccr_q;
                    3'h6: begin
                        mem_addr = `CTI_SWI_VEC_HI;
                        mem_re   = 1'b1;
                    end
                    3'h7: begin
                        mem_addr = `CTI_SWI_VEC_LO;
                        mem_re   = 1'b1;
                    end
                    default: mem_wdata = dat_q;
                endcase
            end
            default: mem_re = 1'b0;
        endcase
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            st_q     <= ST_FETCH;
            pc_q     <= `CTI_PC_RST;
            sp_q     <= `CTI_SP_RST;
            a_q      <= 8'h00;
            h_q      <= 8'h00;
            x_q      <= 8'h00;
            ccr_q    <= `CTI_CCR_RST;
            dat_q    <= 8'h00;
            off_hi_q <= 8'h00;
            off_lo_q <= 8'h00;
            wa_q     <= 16'h0000;
            cls_q    <= C_NOP;
            mode_q   <= `CTI_M_IX;
            cnt_q    <= 2'd0;
            step_q   <= 3'h0;
            pfx_q    <= 1'b0;
        end else begin
            case (st_q)
                ST_FETCH: begin
                    pc_q <= pc_inc;
                    if (!pfx_q && (mem_rdata == `CTI_OP_PFX)) begin
                        pfx_q <= 1'b1;
                    end else begin
                        pfx_q  <= 1'b0;
                        cls_q  <= dec_cls;
                        mode_q <= dec_mode;
                        cnt_q  <= dec_nb;
                        step_q <= 3'h0;
                        case (dec_cls)
                            C_NOP:  st_q <= ST_FETCH;
                            C_TSTA: ccr_q <= flg_ccr;
                            C_TSTX: ccr_q <= flg_ccr;
                            C_TPA:  a_q <= ccr_q;
                            C_TAX:  x_q <= a_q;
                            C_TXA:  a_q <= x_q;
                            C_WAIT: begin
                                ccr_q[`CTI_CCR_I] <= 1'b0;
                                st_q <= ST_WAIT;
                            end
                            C_SWI:  st_q <= ST_SWI;
                            C_TAP:  st_q <= ST_XFER;
                            C_TSX:  st_q <= ST_XFER;
                            C_TXS:  st_q <= ST_XFER;
                            C_BRA:  st_q <= ST_REL;
                            default: st_q <= (dec_nb != 2'd0) ? ST_OPND : ST_READ;
                        endcase
                    end
                end
                ST_OPND: begin
                    // a second byte shifts the first into the high half
                    pc_q     <= pc_inc;
                    off_hi_q <= off_lo_q;
                    off_lo_q <= mem_rdata;
                    cnt_q    <= cnt_q - 2'd1;
                    if (cnt_q == 2'd1) begin
                        if (cls_q == C_MIMD) begin
                            dat_q <= mem_rdata;
                            st_q  <= ST_DST;
                        end else begin
                            st_q <= ST_READ;
                        end
                    end
                end
                ST_READ: begin
                    dat_q <= mem_rdata;
                    case (cls_q)
                        C_TST: begin
                            ccr_q <= flg_ccr;
                            st_q  <= ST_FETCH;
                        end
                        C_LDA: begin
                            a_q   <= mem_rdata;
                            ccr_q <= flg_ccr;
                            st_q  <= ST_FETCH;
                        end
                        C_CBEQ: begin
                            if (postinc) begin
                                {h_q, x_q} <= hx_inc;
                            end
                            st_q <= ST_REL;
                        end
                        C_MDD: st_q <= ST_DST;
                        C_MDIX: begin
                            wa_q <= hx;
                            st_q <= ST_WRITE;
                        end
                        C_MIXD: begin
                            {h_q, x_q} <= hx_inc;
                            st_q <= ST_DST;
                        end
                        default: st_q <= ST_FETCH;
                    endcase
                end
                ST_DST: begin
                    pc_q <= pc_inc;
                    wa_q <= {8'h00, mem_rdata};
                    st_q <= ST_WRITE;
                end
                ST_WRITE: begin
                    if (cls_q == C_MDIX) begin
                        {h_q, x_q} <= hx_inc;
                    end
                    st_q <= ST_FETCH;
                end
                ST_REL: begin
                    pc_q <= pc_inc + rel_ext;
                    st_q <= ST_FETCH;
                end
                ST_XFER: begin
                    case (cls_q)
                        C_TAP:   ccr_q <= flg_ccr;
                        C_TSX:   {h_q, x_q} <= sp_q + 16'h0001;
                        C_TXS:   sp_q <= hx - 16'h0001;
                        default: ccr_q <= ccr_q;
                    endcase
                    st_q <= ST_FETCH;
                end
                ST_SWI: begin
                    step_q <= step_q + 3'h1;
                    if (step_q < 3'h5) begin
                        sp_q <= sp_q - 16'h0001;
                    end
                    if (step_q == 3'h5) begin
                        ccr_q[`CTI_CCR_I] <= 1'b1;
                    end
                    if (step_q == 3'h6) begin
                        pc_q[15:8] <= mem_rdata;
                    end
                    if (step_q == `CTI_SWI_LAST) begin
                        pc_q[7:0] <= mem_rdata;
                        st_q      <= ST_FETCH;
                    end
                end
                ST_WAIT: begin
                    // interrupt service itself lives outside this core
                    if (irq_req) begin
                        st_q <= ST_FETCH;
                    end
                end
                default: st_q <= ST_FETCH;
            endcase
        end
    end
endmodule

// ==== include/cti_map.vh ====
// opcode values, flag positions, mode codes and reset values for the cti core
`ifndef CTI_MAP_VH
`define CTI_MAP_VH

// opcodes
`define CTI_OP_PFX       8'h9E
`define CTI_OP_SWI       8'h83
`define CTI_OP_WAIT      8'h8F
`define CTI_OP_TAP       8'h84
`define CTI_OP_TPA       8'h85
`define CTI_OP_TXS       8'h94
`define CTI_OP_TSX       8'h95
`define CTI_OP_TAX       8'h97
`define CTI_OP_TXA       8'h9F
`define CTI_OP_TST_DIR   8'h3D
`define CTI_OP_TSTA      8'h4D
`define CTI_OP_TSTX      8'h5D
`define CTI_OP_TST_IX1   8'h6D
`define CTI_OP_TST_IX    8'h7D
`define CTI_OP_TST_SP1   8'h6D
`define CTI_OP_MOV_DD    8'h4E
`define CTI_OP_MOV_DIX   8'h5E
`define CTI_OP_MOV_IMD   8'h6E
`define CTI_OP_MOV_IXD   8'h7E
`define CTI_OP_CBEQ_DIR  8'h31
`define CTI_OP_CBEQ_IX1P 8'h61
`define CTI_OP_CBEQ_IXP  8'h71
`define CTI_OP_BRA       8'h20
`define CTI_OP_LDA_EXT   8'hC6
`define CTI_OP_LDA_IX2   8'hD6
`define CTI_OP_LDA_IX1   8'hE6
`define CTI_OP_LDA_IX    8'hF6
`define CTI_OP_LDA_SP2   8'hD6
`define CTI_OP_LDA_SP1   8'hE6

// condition code bit positions
`define CTI_CCR_V        7
`define CTI_CCR_H        4
`define CTI_CCR_I        3
`define CTI_CCR_N        2
`define CTI_CCR_Z        1
`define CTI_CCR_C        0
`define CTI_CCR_ONES     8'h60

// addressing mode codes
`define CTI_M_DIR        4'h0
`define CTI_M_EXT        4'h1
`define CTI_M_IX         4'h2
`define CTI_M_IX1        4'h3
`define CTI_M_IX2        4'h4
`define CTI_M_SP1        4'h5
`define CTI_M_SP2        4'h6
`define CTI_M_IXP        4'h7
`define CTI_M_IX1P       4'h8

// reset values and vectors
`define CTI_PC_RST       16'hF000
`define CTI_SP_RST       16'h00FF
`define CTI_CCR_RST      8'h68
`define CTI_SWI_VEC_HI   16'hFFFC
`define CTI_SWI_VEC_LO   16'hFFFD
`define CTI_SWI_LAST     3'h7

`endif

// ==== rtl/cti_agen.v ====
// effective address generator for the indexed, stack, direct and extended modes
`timescale 1ns/1ps
`include "cti_map.vh"

module cti_agen (
    mode,
    hx,
    sp,
    off_hi,
    off_lo,
    ea
);
    input  wire [3:0]  mode;
    input  wire [15:0] hx;
    input  wire [15:0] sp;
    input  wire [7:0]  off_hi;
    input  wire [7:0]  off_lo;
    output wire [15:0] ea;

    reg [15:0] base;
    reg [15:0] off;

    always @* begin
        base = 16'h0000;
        off  = {8'h00, off_lo};
        case (mode)
            `CTI_M_EXT:  off = {off_hi, off_lo};
            `CTI_M_IX:   {base, off} = {hx, 16'h0000};
            `CTI_M_IXP:  {base, off} = {hx, 16'h0000};
            `CTI_M_IX1:  base = hx;
            `CTI_M_IX1P: base = hx;
            `CTI_M_IX2:  {base, off} = {hx, off_hi, off_lo};
            `CTI_M_SP1:  base = sp;
            `CTI_M_SP2:  {base, off} = {sp, off_hi, off_lo};
            default:     base = 16'h0000;
        endcase
    end

    // offsets are unsigned; the sum wraps at 64k
    assign ea = base + off;
endmodule

// ==== rtl/cti_flags.v ====
// condition code update for test, load and accumulator-to-flags transfer
`timescale 1ns/1ps
`include "cti_map.vh"

module cti_flags (
    ccr_in,
    val,
    ld_nz,
    ld_all,
    ccr_out
);
    input  wire [7:0] ccr_in;
    input  wire [7:0] val;
    input  wire       ld_nz;
    input  wire       ld_all;
    output reg  [7:0] ccr_out;

    always @* begin
        ccr_out = ccr_in;
        if (ld_all) begin
            // the two unused bits always read as one
            ccr_out = val | `CTI_CCR_ONES;
        end else if (ld_nz) begin
            ccr_out[`CTI_CCR_V] = 1'b0;
            ccr_out[`CTI_CCR_N] = val[7];
            ccr_out[`CTI_CCR_Z] = (val == 8'h00);
        end
    end
endmodule

// ==== testbench/cti_mem_model.sv ====
// zero-wait program and data memory on the core bus
`timescale 1ns/1ps
module cti_mem_model (
    input  wire logic        sys_clk,
    input  wire logic [15:0] mem_addr,
    input  wire logic [7:0]  mem_wdata,
    input  wire logic        mem_we,
    input  wire logic        mem_re,
    output logic      [7:0]  mem_rdata
);
    logic [7:0] ram [0:65535];
    logic [7:0] last_q;
    // an idle bus shows the inverse of the last byte, so stale data never looks valid
    assign mem_rdata = mem_re ? ram[mem_addr] : ~last_q;
    initial last_q = 8'h00;
    always @(posedge sys_clk) begin
        if (mem_we) begin
            ram[mem_addr] <= mem_wdata;
        end
        if (mem_re) begin
            last_q <= ram[mem_addr];
        end
    end
endmodule

// ==== testbench/cti_core_asserts.sv ====
// bus, trap and wait checks on the core ports
`timescale 1ns/1ps
module cti_core_asserts (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic [7:0]  mem_rdata,
    input wire logic        irq_req,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0]  mem_wdata,
    input wire logic        mem_we,
    input wire logic        mem_re,
    input wire logic        core_waiting,
    input wire logic [7:0]  acc_val,
    input wire logic [15:0] index_val,
    input wire logic [15:0] stack_pointer,
    input wire logic [15:0] program_counter,
    input wire logic [7:0]  condition_code_register
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire vec_hi = mem_re && mem_addr == 16'hFFFC;

    trap_push_a: assert property (vec_hi |-> $past(mem_we, 2) && $past(mem_we, 6) &&
        !$past(mem_we) && $past(mem_addr, 2) == stack_pointer + 16'h0001 &&
        $past(mem_addr, 6) == stack_pointer + 16'h0005) else $error("trap push order");
    trap_mask_a: assert property (vec_hi |->
        condition_code_register == ($past(mem_wdata, 2) | 8'h08)) else $error("trap mask");
    vec_load_a: assert property (vec_hi |=> mem_re && mem_addr == 16'hFFFD ##1
        program_counter == {$past(mem_rdata, 2), $past(mem_rdata)}) else $error("vector load");
    wait_mask_a: assert property ($rose(core_waiting) |->
        !condition_code_register[3]) else $error("wait mask");
    wait_quiet_a: assert property (core_waiting |-> !mem_we && !mem_re)
        else $error("bus active in wait");
    wait_hold_a: assert property (core_waiting && !irq_req |=>
        core_waiting && $stable(program_counter)) else $error("wait left early");
    wait_exit_a: assert property (core_waiting && irq_req |=> !core_waiting &&
        mem_re && mem_addr == program_counter) else $error("wait exit");
    wake_cause_a: assert property ($fell(core_waiting) |-> $past(irq_req))
        else $error("wake without request");
    flag_ones_a: assert property (condition_code_register[6:5] == 2'b11)
        else $error("fixed flag bits");

    cover property (vec_hi);
    cover property ($rose(core_waiting));
    cover property (core_waiting && irq_req);
endmodule

// ==== testbench/cti_core_tb_top.sv ====
// program-driven bench: waypoints on opcode fetches, then memory contents
`timescale 1ns/1ps
module cti_core_tb_top;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        irq_req = 1'b0;
    logic [7:0]  mem_rdata, mem_wdata, acc_val, condition_code_register;
    logic [15:0] mem_addr, index_val, stack_pointer, program_counter;
    logic        mem_we, mem_re, core_waiting;
    int          mismatches = 0;
    int          cmp_count = 0;
    logic [7:0]  prog [0:65] = '{8'h6E, 8'h80, 8'h10, 8'h4E, 8'h10, 8'h11, 8'h3D, 8'h11,
        8'h85, 8'h97, 8'h5E, 8'h10, 8'h7E, 8'h12, 8'hC6, 8'h12, 8'h34, 8'hE6, 8'h02, 8'hD6,
        8'h01, 8'h00, 8'h9E, 8'hE6, 8'h01, 8'h9E, 8'hD6, 8'h00, 8'h02, 8'h95, 8'h9F, 8'h4D,
        8'h20, 8'h02, 8'h20, 8'h10, 8'h31, 8'h13, 8'h02, 8'h20, 8'h20, 8'hC6, 8'h00, 8'h70,
        8'h97, 8'h94, 8'h83, 8'h9D, 8'h8F, 8'h84, 8'h71, 8'h01, 8'h9D, 8'h61, 8'h02, 8'h05,
        8'h7D, 8'h5D, 8'h9E, 8'h6D, 8'h04, 8'h6D, 8'h01, 8'hF6, 8'h20, 8'hFE};
    // fetch address, acc, index, stack, flags (flags 00: not checked)
    logic [63:0] wp [0:23] = '{
        64'hF009_6C_0000_00FF_6C, 64'hF00A_6C_006C_00FF_6C,
        64'hF00E_6C_006E_00FF_00, 64'hF011_00_006E_00FF_6A,
        64'hF013_77_006E_00FF_68, 64'hF016_99_006E_00FF_6C,
        64'hF019_41_006E_00FF_68, 64'hF01D_42_006E_00FF_68,
        64'hF01E_42_0100_00FF_68, 64'hF01F_00_0100_00FF_68,
        64'hF020_00_0100_00FF_6A, 64'hF024_00_0100_00FF_6A,
        64'hF029_00_0100_00FF_00, 64'hF02E_77_0177_0176_68,
        64'hF030_77_0177_0171_68, 64'hF031_77_0177_0171_60,
        64'hF032_77_0177_0171_77, 64'hF035_77_0178_0171_77,
        64'hF038_77_0179_0171_77, 64'hF039_77_0179_0171_75,
        64'hF03A_77_0179_0171_71, 64'hF03D_77_0179_0171_75,
        64'hF03F_77_0179_0171_73, 64'hF040_80_0179_0171_75};
    logic [39:0] mem_exp [0:8] = '{40'h0010_80, 40'h0011_80, 40'h006C_80, 40'h0012_5A,
        40'h0176_2F, 40'h0175_F0, 40'h0174_77, 40'h0173_77, 40'h0172_68};

    cti_core DUT (.sys_clk(sys_clk), .rst_n(rst_n), .mem_rdata(mem_rdata),
        .irq_req(irq_req), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
        .mem_re(mem_re), .core_waiting(core_waiting), .acc_val(acc_val),
        .index_val(index_val), .stack_pointer(stack_pointer),
        .program_counter(program_counter), .condition_code_register(condition_code_register));
    cti_mem_model u_mem (.sys_clk(sys_clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata));

    always #20 sys_clk = ~sys_clk;

    task automatic stop_test();
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // waits for the opcode fetch at a, the previous instruction having completed
    task automatic fetch_at(input logic [15:0] a);
        int n;
        n = 0;
        @(negedge sys_clk);
        while (!(mem_re === 1'b1 && mem_addr === a) && n < 300) begin
            @(negedge sys_clk);
            n++;
        end
        cmp16("fetch address", a, (n < 300) ? a : mem_addr);
    endtask

    initial begin
        #(40 * 4000);
        mismatches++;
        $display("MISMATCH watchdog expected done seen hang");
        stop_test();
    end

    initial begin
        for (int i = 0; i < 66; i++) u_mem.ram[16'hF000 + i] = prog[i];
        {u_mem.ram[16'h0177], u_mem.ram[16'h0179], u_mem.ram[16'h017A]} = 24'h77_80_00;
        {u_mem.ram[16'h006D], u_mem.ram[16'h0070], u_mem.ram[16'h016E]} = 24'h5A_77_99;
        {u_mem.ram[16'h0100], u_mem.ram[16'h0101], u_mem.ram[16'h1234]} = 24'h41_42_00;
        {u_mem.ram[16'h0013], u_mem.ram[16'hFFFC], u_mem.ram[16'hFFFD]} = 24'h00_F0_30;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 24; i++) begin
            if (i == 15) begin
                repeat (3) @(negedge sys_clk);
                cmp16("waiting", 16'h0001, {15'h0000, core_waiting});
                cmp16("flags in wait", 16'h0060, {8'h00, condition_code_register});
                repeat (20) @(posedge sys_clk);
                irq_req <= 1'b1;
                @(negedge sys_clk);
                cmp16("pc in wait", 16'hF031, program_counter);
                @(posedge sys_clk);
                irq_req <= 1'b0;
            end
            fetch_at(wp[i][63:48]);
            cmp16("acc", {8'h00, wp[i][47:40]}, {8'h00, acc_val});
            cmp16("index", wp[i][39:24], index_val);
            cmp16("stack", wp[i][23:8], stack_pointer);
            if (wp[i][7:0] != 8'h00)
                cmp16("flags", {8'h00, wp[i][7:0]}, {8'h00, condition_code_register});
            $display("test waypoint %h done", wp[i][63:48]);
        end
        for (int i = 0; i < 9; i++)
            cmp16("memory", {8'h00, mem_exp[i][7:0]}, {8'h00, u_mem.ram[mem_exp[i][39:8]]});
        $display("test memory contents done");
        stop_test();
    end
endmodule

bind cti_core cti_core_asserts u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .mem_rdata(mem_rdata), .irq_req(irq_req), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .mem_re(mem_re), .core_waiting(core_waiting), .acc_val(acc_val),
    .index_val(index_val), .stack_pointer(stack_pointer),
    .program_counter(program_counter), .condition_code_register(condition_code_register));
